// ==== include/hpi_pkg.sv ====
// shared constants, carriers and helpers of the high-priority interrupt enable block
// assumes a single 10 MHz system clock and a plain strobe register port
package hpi_pkg;

   // register port geometry
   localparam int unsigned HPI_DATA_W = 16;
   localparam int unsigned HPI_ADDR_W = 4;

   // register indices on the plain port
   localparam logic [HPI_ADDR_W-1:0] HPI_ENABLE_IDX = 4'h7;
   localparam logic [HPI_ADDR_W-1:0] HPI_STATUS_IDX = 4'h8;

   // field positions, shared by enable and status
   localparam int unsigned HPI_BIT_OVERRUN   = 8;
   localparam int unsigned HPI_BIT_ILLOGICAL = 7;
   localparam int unsigned HPI_BIT_DYN_BUS   = 6;
   localparam int unsigned HPI_BIT_SSF       = 5;
   localparam int unsigned HPI_BIT_BIST_END  = 4;
   localparam int unsigned HPI_BIT_BIST_FAIL = 3;
   localparam int unsigned HPI_BIT_LIST_END  = 2;
   localparam int unsigned HPI_BIT_MSG_ERR   = 1;

   // values after reset and implemented-bit mask
   localparam logic [HPI_DATA_W-1:0] HPI_ENABLE_RST = 16'h0000;
   localparam logic [HPI_DATA_W-1:0] HPI_STATUS_RST = 16'h0000;
   localparam logic [HPI_DATA_W-1:0] HPI_IMPL_MASK  = 16'h01fe;
   localparam logic [HPI_DATA_W-1:0] HPI_LIST_MASK  = 16'h0004;

   // timing: clock period and the time allowed for a memory bus grant
   localparam int unsigned HPI_CLK_PERIOD_NS  = 100;
   localparam int unsigned HPI_OVERRUN_TIME_NS = 2000;
   localparam int unsigned HPI_OVERRUN_CYCLES =
      (HPI_OVERRUN_TIME_NS + HPI_CLK_PERIOD_NS - 1) / HPI_CLK_PERIOD_NS;

   // one-cycle event pulses from the terminal core
   typedef struct packed {
      logic illogical_cmd;
      logic dyn_bus_ctrl;
      logic bist_end;
      logic bist_fail;
      logic cmd_list_end;
      logic msg_error;
   } hpi_evt_s;

   // register port request
   typedef struct packed {
      logic [HPI_ADDR_W-1:0] addr;
      logic [HPI_DATA_W-1:0] wdata;
      logic                  wr;
      logic                  rd;
   } hpi_bus_s;

   // grant watchdog states, gray along the path
   typedef enum logic [1:0] {
      HPI_OVR_IDLE = 2'b00,
      HPI_OVR_WAIT = 2'b01,
      HPI_OVR_LATE = 2'b11
   } hpi_ovr_e;

   // address match of a register index
   function automatic logic hpi_hit(input logic [HPI_ADDR_W-1:0] addr,
                                    input logic [HPI_ADDR_W-1:0] idx);
      hpi_hit = (addr == idx);
   endfunction

endpackage

// ==== src/hpi_sticky_bits.sv ====
// sticky event bits with write-one-to-clear
// assumes set and clear vectors are synchronous to the system clock
module hpi_sticky_bits #(
   parameter int unsigned W = 16
) (
   // clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_resetn,
   // set and clear vectors
   input  wire logic [W-1:0] i_set,
   input  wire logic [W-1:0] i_clr,
   // held bits
   output logic      [W-1:0] o_bits
);

   // refuse an empty vector
   initial begin
      if (W < 1) begin
         $error("hpi_sticky_bits: W must be at least 1");
      end
   end

   // a set in the clear cycle wins, so no event is lost
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_bits <= '0;
      end else begin
         o_bits <= (o_bits & ~i_clr) | i_set;
      end
   end

endmodule

// ==== src/hpi_irq_enable.sv ====
// high-priority interrupt enable, status and halt logic of a serial bus terminal
// assumes event pulses and pins are synchronous to i_clk_sys; register port has no wait states
// Notes on behaviour
// - interrupt output rises only for events whose enable bit is set.
// - enable bit 8 flags overrun when memory grant misses its deadline.
// - enable bit 7 flags illogical commands, only in bus controller mode.
// - enable bit 6 flags dynamic bus control mode code, remote terminal only.
// - enable bit 5 flags assertion of the subsystem fail input.
// - enable bit 4 flags completion of built-in self-test.
// - enable bit 3 flags a self-test failure.
// - enable bit 2 flags end of list; other causes supersede it.
// - enable bit 1 flags every message error that arrives while not halted.
// - enabled message error halts the device until status bit 1 written one.
// - while halted, incoming message events and overrun are ignored; subsystem fail and self-test events still set status.
// - writing one clears a status bit; writing zero leaves it.
// - status bit positions match enable bit positions.
//
// The address-and-strobe port was chosen for this implementation.
module hpi_irq_enable
   import hpi_pkg::*;
#(
   parameter int unsigned OVR_CYCLES = hpi_pkg::HPI_OVERRUN_CYCLES
) (
   // clock and reset
   input  wire logic                            i_clk_sys,
   input  wire logic                            i_resetn,
   // register port
   input  wire hpi_pkg::hpi_bus_s               i_bus,
   output logic      [hpi_pkg::HPI_DATA_W-1:0]  o_rd_data,
   // terminal core events and mode
   input  wire hpi_pkg::hpi_evt_s               i_evt,
   input  wire logic                            i_bc_mode,
   // memory bus handshake
   input  wire logic                            i_mem_bus_req,
   input  wire logic                            i_memory_bus_grant_n,
   // subsystem pin
   input  wire logic                            i_subsystem_fail_input_n,
   // interrupt and halt
   output logic                                 o_irq,
   output logic                                 o_halted
);

   localparam int unsigned CNT_W = $clog2(OVR_CYCLES + 1);

   // refuse counts the watchdog cannot serve
   initial begin
      if (OVR_CYCLES < 1 || OVR_CYCLES > 4096) begin
         $error("hpi_irq_enable: OVR_CYCLES out of range");
      end
   end

   logic [HPI_DATA_W-1:0] enable_reg;
   logic [HPI_DATA_W-1:0] status;
   logic [HPI_DATA_W-1:0] evt_raw;
   logic [HPI_DATA_W-1:0] set_other;
   logic [HPI_DATA_W-1:0] set_vec;
   logic [HPI_DATA_W-1:0] clr_vec;
   logic [HPI_DATA_W-1:0] rd_data_next;
   logic                  wr_enable;
   logic                  wr_status;
   logic                  halted;
   logic                  ssf_now;
   logic                  ssf_d_reg;
   logic                  ssf_rise;
   logic                  grant;
   logic                  ovr_fire;
   logic                  list_ok;
   hpi_ovr_e              ovr_state_reg;
   hpi_ovr_e              ovr_state_next;
   logic [CNT_W-1:0]      ovr_cnt_reg;
   logic [CNT_W-1:0]      ovr_cnt_next;

   // write decode
   assign wr_enable = i_bus.wr && hpi_hit(i_bus.addr, HPI_ENABLE_IDX);
   assign wr_status = i_bus.wr && hpi_hit(i_bus.addr, HPI_STATUS_IDX);

   // enable register; reserved bits never stored
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         enable_reg <= HPI_ENABLE_RST;
      end else if (wr_enable) begin
         enable_reg <= i_bus.wdata & HPI_IMPL_MASK;
      end
   end

   // subsystem fail pin is active low; flag its assertion edge
   assign ssf_now  = ~i_subsystem_fail_input_n;
   assign ssf_rise = ssf_now & ~ssf_d_reg;

   // previous pin level for edge detection
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ssf_d_reg <= 1'b0;
      end else begin
         ssf_d_reg <= ssf_now;
      end
   end

   // grant is active low on the pin
   assign grant = ~i_memory_bus_grant_n;

   // grant watchdog: counts cycles a request waits without grant
   always_comb begin
      ovr_state_next = ovr_state_reg;
      ovr_cnt_next   = ovr_cnt_reg;
      ovr_fire       = 1'b0;
      unique case (ovr_state_reg)
         HPI_OVR_IDLE: begin
            if (i_mem_bus_req && !grant) begin
               ovr_state_next = HPI_OVR_WAIT;
               ovr_cnt_next   = CNT_W'(1);
            end
         end
         HPI_OVR_WAIT: begin
            if (!i_mem_bus_req || grant) begin
               ovr_state_next = HPI_OVR_IDLE;
               ovr_cnt_next   = '0;
            end else if (ovr_cnt_reg == CNT_W'(OVR_CYCLES)) begin
               ovr_fire       = 1'b1;
               ovr_state_next = HPI_OVR_LATE;
            end else begin
               ovr_cnt_next = ovr_cnt_reg + CNT_W'(1);
            end
         end
         HPI_OVR_LATE: begin
            // one overrun per request; wait for the request to drop
            if (!i_mem_bus_req) begin
               ovr_state_next = HPI_OVR_IDLE;
               ovr_cnt_next   = '0;
            end
         end
         default: begin
            ovr_state_next = HPI_OVR_IDLE;
            ovr_cnt_next   = '0;
         end
      endcase
   end

   // watchdog state and counter
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ovr_state_reg <= HPI_OVR_IDLE;
         ovr_cnt_reg   <= '0;
      end else begin
         ovr_state_reg <= ovr_state_next;
         ovr_cnt_reg   <= ovr_cnt_next;
      end
   end

   // raw causes placed at their shared bit positions; halt blocks message events
   always_comb begin
      evt_raw                    = '0;
      evt_raw[HPI_BIT_OVERRUN]   = ovr_fire & ~halted;
      evt_raw[HPI_BIT_ILLOGICAL] = i_evt.illogical_cmd & i_bc_mode & ~halted;
      evt_raw[HPI_BIT_DYN_BUS]   = i_evt.dyn_bus_ctrl & ~i_bc_mode & ~halted;
      evt_raw[HPI_BIT_SSF]       = ssf_rise;
      evt_raw[HPI_BIT_BIST_END]  = i_evt.bist_end;
      evt_raw[HPI_BIT_BIST_FAIL] = i_evt.bist_fail;
      evt_raw[HPI_BIT_LIST_END]  = i_evt.cmd_list_end & i_bc_mode & ~halted;
      evt_raw[HPI_BIT_MSG_ERR]   = i_evt.msg_error & ~halted;
   end

   // enabled causes other than end of list
   assign set_other = evt_raw & enable_reg & ~HPI_LIST_MASK;

   // end of list yields to any other enabled cause, arriving or still pending
   assign list_ok = (set_other == '0) && ((status & ~HPI_LIST_MASK) == '0);

   // status set vector; the enable gates each cause in its own position
   always_comb begin
      set_vec                   = set_other;
      set_vec[HPI_BIT_LIST_END] = evt_raw[HPI_BIT_LIST_END] & enable_reg[HPI_BIT_LIST_END] & list_ok;
   end

   // write-one-to-clear of the status register, reserved bits ignored
   assign clr_vec = wr_status ? (i_bus.wdata & HPI_IMPL_MASK) : '0;

   // sticky status bits
   hpi_sticky_bits #(
      .W (HPI_DATA_W)
   ) u_status (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_set     (set_vec),
      .i_clr     (clr_vec),
      .o_bits    (status)
   );

   // message error status bit is only set when enabled, so it is the halt
   assign halted = status[HPI_BIT_MSG_ERR];

   // interrupt and halt outputs from flops
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_irq    <= 1'b0;
         o_halted <= 1'b0;
      end else begin
         o_irq    <= |(status & enable_reg);
         o_halted <= halted;
      end
   end

   // read mux; unmapped addresses and reserved bits read zero
   always_comb begin
      rd_data_next = '0;
      if (hpi_hit(i_bus.addr, HPI_ENABLE_IDX)) begin
         rd_data_next = enable_reg & HPI_IMPL_MASK;
      end else if (hpi_hit(i_bus.addr, HPI_STATUS_IDX)) begin
         rd_data_next = status & HPI_IMPL_MASK;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rd_data <= HPI_STATUS_RST;
      end else if (i_bus.rd) begin
         o_rd_data <= rd_data_next;
      end else begin
         o_rd_data <= '0;
      end
   end

endmodule

// ==== tb/hpi_irq_enable_chk.sv ====
// port checker of the interrupt enable block
// assumes one clock domain; bound onto hpi_irq_enable
module hpi_irq_enable_chk
   import hpi_pkg::*;
#(parameter int unsigned OVR_CYCLES = 20) (
   // clock and reset
   input wire logic              i_clk_sys,
   input wire logic              i_resetn,
   // watched inputs
   input wire hpi_pkg::hpi_bus_s i_bus,
   input wire hpi_pkg::hpi_evt_s i_evt,
   input wire logic              i_mem_bus_req,
   input wire logic              i_subsystem_fail_input_n,
   // watched outputs
   input wire logic [15:0]       o_rd_data,
   input wire logic              o_irq,
   input wire logic              o_halted
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   logic cause;
   logic clr1;
   // inputs able to raise the interrupt, and the halt release write
   assign cause = (|i_evt) | i_bus.wr | i_mem_bus_req | !i_subsystem_fail_input_n;
   assign clr1  = i_bus.wr && i_bus.addr == HPI_STATUS_IDX && i_bus.wdata[1];
   sequence s_st_rd;
      i_bus.rd && i_bus.addr == HPI_STATUS_IDX;
   endsequence
   a_rd_idle_zero: assert property (!$past(i_bus.rd) |-> o_rd_data == 16'h0000)
      else $error("read data not idle");
   a_rd_resv_zero: assert property (o_rd_data[15:9] == 7'h00 && !o_rd_data[0])
      else $error("reserved bit read as one");
   a_irq_rise_cause: assert property ($rose(o_irq) |-> $past(cause, 2))
      else $error("interrupt rose with no cause");
   a_irq_fall_write: assert property ($fell(o_irq) |-> $past(i_bus.wr, 2))
      else $error("interrupt fell with no write");
   a_halt_rise_err: assert property ($rose(o_halted) |-> $past(i_evt.msg_error, 2))
      else $error("halt with no message error");
   a_halt_fall_clr: assert property ($fell(o_halted) |-> $past(clr1, 2))
      else $error("halt left with no clear");
   a_halt_held: assert property (o_halted && !clr1 && !$past(clr1) |=> o_halted)
      else $error("halt dropped early");
   a_halt_rd_bit: assert property (s_st_rd |=> o_rd_data[1] == o_halted)
      else $error("status bit one differs from halt");
endmodule
bind hpi_irq_enable hpi_irq_enable_chk #(.OVR_CYCLES(OVR_CYCLES)) u_chk (.i_clk_sys(i_clk_sys),
   .i_resetn(i_resetn), .i_bus(i_bus), .i_evt(i_evt), .i_mem_bus_req(i_mem_bus_req),
   .i_subsystem_fail_input_n(i_subsystem_fail_input_n), .o_rd_data(o_rd_data), .o_irq(o_irq),
   .o_halted(o_halted));

// ==== tb/hpi_irq_enable_tb.sv ====
// bench of the interrupt enable block
// assumes hpi_pkg and the checker are compiled first
module hpi_irq_enable_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import hpi_pkg::*;
   logic        clk = 1'b0, resetn = 1'b0, bc = 1'b1, irq, hlt;
   logic        req = 1'b0, gnt_n = 1'b1, ssf_n = 1'b1;
   logic [15:0] rdd;
   hpi_bus_s    bus = '0;
   hpi_evt_s    evt = '0;
   int          failures = 0, cmp_count = 0;
   // 10 MHz clock
   always #50 clk = ~clk;
   hpi_irq_enable #(.OVR_CYCLES(3)) u_dut (.i_clk_sys(clk), .i_resetn(resetn), .i_bus(bus),
      .o_rd_data(rdd), .i_evt(evt), .i_bc_mode(bc), .i_mem_bus_req(req), .i_memory_bus_grant_n(gnt_n),
      .i_subsystem_fail_input_n(ssf_n), .o_irq(irq), .o_halted(hlt));
   // compare and count
   task automatic chk(input logic [15:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // register write; read with compare
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] x);
      @(posedge clk);
      bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      @(negedge clk);
      chk(rdd, x);
   endtask
   // wait edges, then compare {irq, halt}
   task automatic see(input int n, input logic [1:0] x);
      repeat (n) @(posedge clk);
      @(negedge clk);
      chk(16'({irq, hlt}), 16'(x));
   endtask
   // one-cycle event pulse
   task automatic pulse(input int e);
      @(posedge clk);
      evt <= hpi_evt_s'(6'h01 << e);
      @(posedge clk);
      evt <= '0;
   endtask
   // reset values, reserved bits, unmapped place
   task automatic t_regs();
      rd(HPI_ENABLE_IDX, 16'h0000);
      rd(HPI_STATUS_IDX, 16'h0000);
      wr(HPI_ENABLE_IDX, 16'hffff);
      rd(HPI_ENABLE_IDX, 16'h01fe);
      rd(4'h3, 16'h0000);
      $display("regs ok");
   endtask
   // event enabled, then disabled or in the other mode
   task automatic t_evt(input int e, input logic [15:0] s, input logic m, g, input logic [1:0] x);
      wr(HPI_ENABLE_IDX, s);
      bc <= m;
      pulse(e);
      see(1, x);
      rd(HPI_STATUS_IDX, s);
      wr(HPI_STATUS_IDX, s);
      see(1, 2'b00);
      wr(HPI_ENABLE_IDX, g ? s : ~s & 16'h01fe);
      bc <= m ^ g;
      pulse(e);
      see(1, 2'b00);
      $display("event %0d ok", e);
   endtask
   // message error halts until bit one is written
   task automatic t_halt();
      wr(HPI_ENABLE_IDX, 16'h0042);
      bc <= 1'b0;
      pulse(0);
      pulse(4);
      wr(HPI_STATUS_IDX, 16'h0000);
      see(2, 2'b11);
      rd(HPI_STATUS_IDX, 16'h0002);
      wr(HPI_STATUS_IDX, 16'h0002);
      see(1, 2'b00);
      $display("halt ok");
   endtask
   // subsystem fail edge and memory grant deadline
   task automatic t_pins();
      wr(HPI_ENABLE_IDX, 16'h0120);
      ssf_n <= 1'b0;
      see(2, 2'b10);
      wr(HPI_STATUS_IDX, 16'h0020);
      req <= 1'b1;
      see(4, 2'b00);
      see(1, 2'b10);
      wr(HPI_STATUS_IDX, 16'h0100);
      ssf_n <= 1'b1;
      req <= 1'b0;
      @(posedge clk);
      req <= 1'b1;
      gnt_n <= 1'b0;
      see(8, 2'b00);
      @(posedge clk);
      req <= 1'b0;
      gnt_n <= 1'b1;
      $display("pins ok");
   endtask
   // verdict and end of run
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // reset, then the scenarios
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_evt(5, 16'h0080, 1'b1, 1'b1, 2'b10);
      t_evt(4, 16'h0040, 1'b0, 1'b1, 2'b10);
      t_evt(3, 16'h0010, 1'b1, 1'b0, 2'b10);
      t_evt(2, 16'h0008, 1'b1, 1'b0, 2'b10);
      t_evt(1, 16'h0004, 1'b1, 1'b1, 2'b10);
      t_evt(0, 16'h0002, 1'b1, 1'b0, 2'b11);
      t_halt();
      t_pins();
      test_done();
   end
endmodule
